//--- src/ctce_pkg.sv
/*
  ctce_pkg: constants, register map and state types of the contactless
  target command engine.
  Assumes a 32-bit APB master and a 40 MHz system clock.
*/
package ctce_pkg;
  // command codes held in command_register[3:0]
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [3:0] CMD_CONFIG = 4'h1;
  localparam logic [3:0] CMD_RANDOM = 4'h2;
  localparam logic [3:0] CMD_CRC = 4'h3;
  localparam logic [3:0] CMD_TRANSMIT = 4'h4;
  localparam logic [3:0] CMD_KEEP = 4'h7;
  localparam logic [3:0] CMD_RECEIVE = 4'h8;
  localparam logic [3:0] CMD_TRANSCEIVE = 4'hC;
  localparam logic [3:0] CMD_AUTO_ACT = 4'hD;
  localparam logic [3:0] CMD_SOFT_RESET = 4'hF;
  // byte offsets
  localparam logic [7:0] A_COMMAND = 8'h00;
  localparam logic [7:0] A_FIFO_DATA = 8'h04;
  localparam logic [7:0] A_FIFO_LEVEL = 8'h08;
  localparam logic [7:0] A_CONTROL = 8'h0C;
  localparam logic [7:0] A_MODE = 8'h10;
  localparam logic [7:0] A_BIT_FRAMING = 8'h14;
  localparam logic [7:0] A_CRC_RESULT = 8'h18;
  localparam logic [7:0] A_STATUS2 = 8'h1C;
  localparam logic [7:0] A_SELF_TEST = 8'h20;
  localparam logic [7:0] A_TEST_SEL = 8'h24;
  localparam logic [7:0] A_SERIAL_RATE = 8'h28;
  localparam logic [7:0] A_VERSION = 8'h2C;
  localparam logic [7:0] A_TX_MODE = 8'h30;
  localparam logic [7:0] A_RX_MODE = 8'h34;
  // fields: command bit 4 receiver off, bit 5 power down; mode[1:0]
  // preset, mode bit 2 detector off; framing bit 7 start; tx/rx mode
  // bit 7 crc enable, [5:4] detected speed
  localparam int B_RCV_OFF = 4;
  localparam int B_PDOWN = 5;
  localparam int B_MODE_DET_OFF = 2;
  localparam int B_START = 7;
  localparam int B_CRC_EN = 7;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_PRE0 = 16'h0000;
  localparam logic [15:0] CRC_PRE1 = 16'h6363;
  localparam logic [15:0] CRC_PRE2 = 16'hA671;
  localparam logic [15:0] CRC_PRE3 = 16'hFFFF;
  localparam logic [3:0] SELF_TEST_ON = 4'h9;
  localparam logic [6:0] SELF_TEST_LEN = 7'h40;
  localparam logic [7:0] TSEL_RX = 8'h07;
  localparam logic [7:0] TSEL_CLK = 8'h0D;
  localparam logic [7:0] TSEL_TIMER = 8'h19;
  localparam logic [7:0] SERIAL_RATE_RST = 8'h00;
  localparam logic [7:0] VERSION_ID = 8'h5A; // arbitrary value
  localparam logic [1:0] MODE_P2P_106 = 2'h0;
  localparam logic [1:0] MODE_CARD_A = 2'h2;
  localparam logic AC_TX_CRC = 1'b1;
  localparam logic AC_RX_CRC = 1'b1;
  localparam int FIFO_DEPTH = 64;
  localparam logic [6:0] FIFO_FULL = 7'h40;

  typedef enum logic [1:0] {PH_RUN, PH_TX, PH_RX, PH_DONE} ctce_ph_t;

  typedef struct packed {
    logic [6:0] rx_sig; // data, coll, valid, stop, receiver_reset_state, rf, env
    logic [6:0] clk_sig;
    logic timer_running;
  } ctce_test_t;

  typedef struct packed {
    logic [3:0] cmd;
    logic rcv_off;
    logic pdown;
    logic initiator;
    logic [7:0] mode;
    logic start_send;
    logic target_act;
    logic [3:0] self_test;
    logic [7:0] test_sel;
    logic [7:0] serial_rate;
    logic [7:0] tx_mode;
    logic [7:0] rx_mode;
    logic [15:0] crc;
    ctce_ph_t ph;
    logic [6:0] st_cnt;
    logic [1:0] ac_mode;
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [5:0] wptr;
    logic [5:0] rptr;
    logic [6:0] cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic tx_valid;
    logic [7:0] tx_data;
    logic rx_en;
    logic tx_crc_en;
    logic rx_crc_en;
    logic irq;
    logic [6:0] test_bus;
  } ctce_st_t;
endpackage : ctce_pkg

//--- src/ctce_engine.sv
/*
  ctce_engine: command state machine of the contactless target front end,
  with APB register file, 64-byte FIFO, CRC coprocessor and test bus.
  Assumes the RF framing logic outside delivers received bytes, frame
  ends and activation events as one-cycle pulses on sys_clk_in.
*/
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps
module ctce_engine (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_sof_in,
  input wire logic rx_end_in,
  input wire logic rf_field_in,
  input wire logic mode_valid_in,
  input wire logic [1:0] mode_in,
  input wire logic act_done_in,
  input wire logic anticoll_run_in,
  input wire ctce_pkg::ctce_test_t test_in,
  output logic rx_enable_out,
  output logic tx_crc_en_out,
  output logic rx_crc_en_out,
  output logic irq_out,
  output logic power_down_out,
  output logic [7:0] serial_rate_out,
  output logic [6:0] test_bus_out
);
  import ctce_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // ==========================================================
  // helpers
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  function automatic logic [15:0] crc_preset(input logic [1:0] sel);
    case (sel)
      2'h0: crc_preset = CRC_PRE0;
      2'h1: crc_preset = CRC_PRE1;
      2'h2: crc_preset = CRC_PRE2;
      default: crc_preset = CRC_PRE3;
    endcase
  endfunction : crc_preset

  function automatic logic is_106(input logic [1:0] m);
    return (m == MODE_P2P_106) || (m == MODE_CARD_A);
  endfunction : is_106

  // ==========================================================
  // state
  ctce_st_t st;
  ctce_st_t next_st;
  ctce_st_t rst_val;
  logic acc;
  logic wr;
  logic [7:0] pop_byte;
  logic popped;
  logic [7:0] push_byte;
  logic pushed;

  always_comb begin
    rst_val = '0;
    rst_val.serial_rate = SERIAL_RATE_RST;
    rst_val.ph = PH_RUN;
  end

  always_comb begin
    next_st = st;
    pop_byte = st.mem[st.rptr];
    popped = 1'b0;
    push_byte = '0;
    pushed = 1'b0;
    acc = psel_in && penable_in && st.pready;
    wr = acc && pwrite_in;
    next_st.pready = psel_in && penable_in && !st.pready;
    next_st.irq = 1'b0;

    // ========================================================
    // register reads, answered one cycle into the access phase
    if (psel_in && penable_in && !st.pready) begin
      next_st.prdata = '0;
      next_st.pslverr = 1'b0;
      case (paddr_in)
        A_COMMAND: next_st.prdata[7:0] = {2'b00, st.pdown, st.rcv_off,
                                          st.cmd};
        A_FIFO_DATA: next_st.prdata[7:0] = pop_byte;
        A_FIFO_LEVEL: next_st.prdata[6:0] = st.cnt;
        A_CONTROL: next_st.prdata[0] = st.initiator;
        A_MODE: next_st.prdata[7:0] = st.mode;
        A_BIT_FRAMING: next_st.prdata[B_START] = st.start_send;
        A_CRC_RESULT: next_st.prdata[15:0] = st.crc;
        A_STATUS2: next_st.prdata[0] = st.target_act;
        A_SELF_TEST: next_st.prdata[3:0] = st.self_test;
        A_TEST_SEL: next_st.prdata[7:0] = st.test_sel;
        A_SERIAL_RATE: next_st.prdata[7:0] = st.serial_rate;
        A_VERSION: next_st.prdata[7:0] = VERSION_ID;
        A_TX_MODE: next_st.prdata[7:0] = st.tx_mode;
        A_RX_MODE: next_st.prdata[7:0] = st.rx_mode;
        default: next_st.pslverr = 1'b1;
      endcase
    end
    if (acc && !pwrite_in && paddr_in == A_FIFO_DATA && st.cnt != 0) begin
      popped = 1'b1;
    end

    // ========================================================
    // command sequencing
    case (st.cmd)
      CMD_CRC: begin
        if (st.ph == PH_TX) begin
          // self test: stream deterministic bytes into the fifo
          if (st.st_cnt != SELF_TEST_LEN && st.cnt != FIFO_FULL) begin
            next_st.crc = crc_byte(st.crc, {1'b0, st.st_cnt});
            push_byte = next_st.crc[7:0];
            pushed = 1'b1;
            next_st.st_cnt = st.st_cnt + 7'd1;
          end
        end else if (st.cnt != 0 && !popped) begin
          // never ends: an empty fifo only pauses the hash
          popped = 1'b1;
          next_st.crc = crc_byte(st.crc, pop_byte);
        end
      end
      CMD_TRANSMIT, CMD_TRANSCEIVE: begin
        if (st.tx_valid && tx_ready_in) begin
          next_st.tx_valid = 1'b0;
        end
        if (st.ph == PH_TX) begin
          if (!next_st.tx_valid && st.cnt != 0 && !popped) begin
            popped = 1'b1;
            next_st.tx_valid = 1'b1;
            next_st.tx_data = pop_byte;
          end else if (!st.tx_valid && st.cnt == 0) begin
            if (st.cmd == CMD_TRANSMIT) begin
              next_st.cmd = CMD_IDLE;
            end else begin
              next_st.ph = PH_RX;
              next_st.start_send = 1'b0;
            end
          end
        end else if (st.ph == PH_RX && rx_end_in) begin
          next_st.ph = PH_RUN;
          next_st.irq = 1'b1;
        end else if (st.ph == PH_RUN && st.start_send) begin
          next_st.ph = PH_TX;
        end
      end
      CMD_RECEIVE: begin
        if (rx_end_in) begin
          next_st.cmd = CMD_IDLE;
          next_st.irq = 1'b1;
        end
      end
      CMD_AUTO_ACT: begin
        if (!rf_field_in) begin
          next_st.ph = PH_RUN;
        end else begin
          if (mode_valid_in && !st.mode[B_MODE_DET_OFF]) begin
            next_st.ac_mode = mode_in;
            next_st.tx_mode[5:4] = mode_in;
            next_st.rx_mode[5:4] = mode_in;
            next_st.ph = PH_RX;
          end
          if (rx_sof_in) begin
            // each frame replaces the last one in the fifo
            next_st.wptr = st.rptr + {5'd0, popped};
            next_st.cnt = {6'd0, popped};
          end
          if (act_done_in) begin
            next_st.cmd = CMD_TRANSCEIVE;
            next_st.ph = PH_RUN;
            next_st.target_act = 1'b1;
            next_st.irq = 1'b1;
            if (is_106(st.ac_mode) && anticoll_run_in && st.cnt > 1) begin
              next_st.wptr = st.wptr - 6'd2;
              next_st.cnt = st.cnt - 7'd2;
            end
          end
        end
      end
      CMD_SOFT_RESET: begin
        // the fifo and the configuration buffer outside survive
        next_st = rst_val;
        next_st.mem = st.mem;
        next_st.wptr = st.wptr;
        next_st.rptr = st.rptr;
        next_st.cnt = st.cnt;
        next_st.pready = psel_in && penable_in && !st.pready;
      end
      CMD_CONFIG, CMD_RANDOM: next_st.cmd = CMD_IDLE;
      default: ;
    endcase

    // ========================================================
    // receive path into the fifo; takes priority over host writes
    if (rx_valid_in && next_st.rx_en) begin
      push_byte = rx_data_in;
      pushed = 1'b1;
    end else if (wr && paddr_in == A_FIFO_DATA && !pushed) begin
      push_byte = pwdata_in[7:0];
      pushed = 1'b1;
    end
    if (popped) begin
      next_st.rptr = next_st.rptr + 6'd1;
    end
    if (pushed && (next_st.cnt != FIFO_FULL || popped)) begin
      next_st.mem[next_st.wptr] = push_byte;
      next_st.wptr = next_st.wptr + 6'd1;
    end else begin
      pushed = 1'b0;
    end
    next_st.cnt = next_st.cnt + {6'd0, pushed} - {6'd0, popped};

    // ========================================================
    // register writes; a new code aborts whatever runs
    if (wr) begin
      case (paddr_in)
        A_COMMAND: begin
          next_st.rcv_off = pwdata_in[B_RCV_OFF];
          next_st.pdown = pwdata_in[B_PDOWN];
          if (pwdata_in[3:0] != CMD_KEEP) begin
            next_st.cmd = pwdata_in[3:0];
            next_st.ph = PH_RUN;
            next_st.tx_valid = 1'b0;
            next_st.st_cnt = '0;
            if (pwdata_in[3:0] == CMD_TRANSMIT) begin
              next_st.ph = PH_TX;
            end
            if (pwdata_in[3:0] == CMD_CRC) begin
              next_st.crc = crc_preset(st.mode[1:0]);
              if (st.self_test == SELF_TEST_ON) begin
                next_st.ph = PH_TX;
              end
            end
          end
        end
        A_CONTROL: next_st.initiator = pwdata_in[0];
        A_MODE: next_st.mode = pwdata_in[7:0];
        A_BIT_FRAMING: next_st.start_send = pwdata_in[B_START];
        A_SELF_TEST: next_st.self_test = pwdata_in[3:0];
        A_TEST_SEL: next_st.test_sel = pwdata_in[7:0];
        A_SERIAL_RATE: next_st.serial_rate = pwdata_in[7:0];
        A_TX_MODE: next_st.tx_mode = pwdata_in[7:0];
        A_RX_MODE: next_st.rx_mode = pwdata_in[7:0];
        default: ;
      endcase
    end

    // ========================================================
    // air side controls and test bus
    next_st.rx_en = !next_st.rcv_off && (next_st.cmd == CMD_RECEIVE ||
      next_st.cmd == CMD_AUTO_ACT ||
      (next_st.cmd == CMD_TRANSCEIVE && next_st.ph == PH_RX));
    if (next_st.cmd == CMD_AUTO_ACT && is_106(next_st.ac_mode)) begin
      next_st.tx_crc_en = AC_TX_CRC;
      next_st.rx_crc_en = AC_RX_CRC;
    end else begin
      next_st.tx_crc_en = next_st.tx_mode[B_CRC_EN];
      next_st.rx_crc_en = next_st.rx_mode[B_CRC_EN];
    end
    case (st.test_sel)
      TSEL_RX: next_st.test_bus = test_in.rx_sig;
      TSEL_CLK: next_st.test_bus = test_in.clk_sig;
      TSEL_TIMER: next_st.test_bus = {5'd0, test_in.timer_running, 1'b0};
      default: next_st.test_bus = '0;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
      st.serial_rate <= SERIAL_RATE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata_out = st.prdata;
  assign pready_out = st.pready;
  assign pslverr_out = st.pslverr;
  assign tx_valid_out = st.tx_valid;
  assign tx_data_out = st.tx_data;
  assign rx_enable_out = st.rx_en;
  assign tx_crc_en_out = st.tx_crc_en;
  assign rx_crc_en_out = st.rx_crc_en;
  assign irq_out = st.irq;
  assign power_down_out = st.pdown;
  assign serial_rate_out = st.serial_rate;
  assign test_bus_out = st.test_bus;

  // ==========================================================
  // checks
  crc_preset_a: assert property (wr && paddr_in == A_COMMAND &&
    pwdata_in[3:0] == CMD_CRC |=> st.cmd == CMD_CRC &&
    st.crc == crc_preset(st.mode[1:0])) else $error("crc preset wrong");
  crc_hold_a: assert property (st.cmd == CMD_CRC &&
    !(acc && paddr_in == A_COMMAND) |=> st.cmd == CMD_CRC)
    else $error("crc command ended");
  keep_code_a: assert property (wr && paddr_in == A_COMMAND &&
    pwdata_in[3:0] == CMD_KEEP && st.cmd == CMD_CRC |=> st.cmd == CMD_CRC)
    else $error("keep code changed command");
  tx_end_a: assert property (st.cmd == CMD_TRANSMIT &&
    st.ph == PH_TX && st.cnt == 0 && !st.tx_valid && !acc && !rx_valid_in
    |=> st.cmd == CMD_IDLE) else $error("transmit did not end");
  rx_end_a: assert property (st.cmd == CMD_RECEIVE && rx_end_in &&
    !acc |=> st.cmd == CMD_IDLE && st.irq) else $error("receive not ended");
  trx_wait_a: assert property (st.cmd == CMD_TRANSCEIVE &&
    st.ph == PH_RUN && !st.start_send |=> !st.tx_valid)
    else $error("transmit without start");
  act_done_a: assert property (st.cmd == CMD_AUTO_ACT &&
    rf_field_in && act_done_in && !acc |=> st.cmd == CMD_TRANSCEIVE &&
    st.target_act) else $error("activation did not finish");
  act_irq_a: assert property (st.cmd == CMD_AUTO_ACT &&
    !act_done_in |=> !st.irq) else $error("interrupt during activation");
  soft_rst_a: assert property (st.cmd == CMD_SOFT_RESET |=>
    st.cmd == CMD_IDLE && st.mode == '0 && !st.target_act &&
    st.serial_rate == SERIAL_RATE_RST) else $error("soft reset incomplete");
  field_loss_a: assert property (st.cmd == CMD_AUTO_ACT &&
    !rf_field_in && !acc |=> st.cmd == CMD_AUTO_ACT && st.ph == PH_RUN)
    else $error("lost field ended activation");
endmodule : ctce_engine

//--- test/ctce_rf_peer.sv
/*
  ctce_rf_peer: behavioural air-side partner of the command engine.
  Assumes the bench calls its tasks and reads got; one clock, no reset.
*/
`timescale 1ns/10ps
module ctce_rf_peer (
  input wire logic clk_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_sof_out,
  output logic rx_end_out,
  output logic rf_field_out,
  output logic mode_valid_out,
  output logic [1:0] mode_out,
  output logic act_done_out,
  output logic anticoll_run_out
);
  logic [7:0] got[$];
  logic slow = 1'b0;
  logic [1:0] tick = 2'h0;
  initial begin
    {tx_ready_out, rx_valid_out, rx_sof_out, rx_end_out} = 4'h0;
    {mode_valid_out, act_done_out, anticoll_run_out} = 3'h0;
    rx_data_out = 8'h00;
    mode_out = 2'h0;
    rf_field_out = 1'b1;
  end
  // ====================================================================
  // byte sink: stalls three cycles in four when slow
  always @(posedge clk_in) begin
    tick <= tick + 2'h1;
    if (tx_valid_in === 1'b1 && tx_ready_out) got.push_back(tx_data_in);
    tx_ready_out <= !slow || tick == 2'h3;
  end
  // ====================================================================
  // frame source: released data shows the inverse of the last byte
  task automatic send(input logic [7:0] b[$]);
    @(posedge clk_in);
    rx_sof_out <= 1'b1;
    foreach (b[i]) begin
      @(posedge clk_in);
      rx_sof_out <= 1'b0;
      rx_valid_out <= 1'b1;
      rx_data_out <= b[i];
    end
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~b[b.size()-1];
    rx_end_out <= 1'b1;
    @(posedge clk_in);
    rx_end_out <= 1'b0;
  endtask : send
  task automatic set_field(input logic v);
    @(posedge clk_in);
    rf_field_out <= v;
  endtask : set_field
  task automatic pulse(input logic [1:0] m, input logic done, input logic r);
    @(posedge clk_in);
    {mode_valid_out, act_done_out} <= {!done, done};
    mode_out <= m;
    anticoll_run_out <= r;
    @(posedge clk_in);
    {mode_valid_out, act_done_out} <= 2'h0;
    mode_out <= ~m;
    anticoll_run_out <= ~r;
  endtask : pulse
endmodule : ctce_rf_peer

//--- test/ctce_engine_bench.sv
/*
  ctce_engine_bench: register-level tests of the command engine.
  Assumes ctce_pkg, the engine and the air-side partner are compiled first.
*/
`timescale 1ns/10ps
module ctce_engine_bench;
  import ctce_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, err, tx_valid, rx_valid, rx_sof, rx_end, rf_field;
  logic mode_valid, act_done, run, tx_ready, irq, power_down;
  logic rx_en, tx_crc, rx_crc;
  logic [7:0] tx_data, rx_data, serial_rate;
  logic [1:0] mode;
  logic [6:0] test_bus;
  logic [15:0] crc;
  ctce_test_t tst = {7'h55, 7'h2A, 1'b1};
  int mismatches = 0;
  int checks_done = 0;
  int irqs = 0;
  int base = 0;
  int cyc = 0;
  logic [15:0] pre[4] = '{CRC_PRE0, CRC_PRE1, CRC_PRE2, CRC_PRE3};
  logic [7:0] sels[3] = '{TSEL_RX, TSEL_CLK, TSEL_TIMER};
  logic [6:0] buses[3] = '{7'h55, 7'h2A, 7'h02};

  initial begin
    forever #12.5 clk = ~clk;
  end

  ctce_engine DUT (.sys_clk_in(clk), .rst_in(rst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .tx_valid_out(tx_valid), .tx_data_out(tx_data),
    .tx_ready_in(tx_ready), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
    .rx_sof_in(rx_sof), .rx_end_in(rx_end), .rf_field_in(rf_field),
    .mode_valid_in(mode_valid), .mode_in(mode), .act_done_in(act_done),
    .anticoll_run_in(run), .test_in(tst), .rx_enable_out(rx_en),
    .tx_crc_en_out(tx_crc), .rx_crc_en_out(rx_crc), .irq_out(irq),
    .power_down_out(power_down), .serial_rate_out(serial_rate),
    .test_bus_out(test_bus));

  ctce_rf_peer peer (.clk_in(clk), .tx_valid_in(tx_valid),
    .tx_data_in(tx_data), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid),
    .rx_data_out(rx_data), .rx_sof_out(rx_sof), .rx_end_out(rx_end),
    .rf_field_out(rf_field), .mode_valid_out(mode_valid),
    .mode_out(mode), .act_done_out(act_done), .anticoll_run_out(run));

  // ====================================================================
  // helpers
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'b1) irqs++;
    if (cyc == 40000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite} <= {1'b1, 1'b0, w};
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd
  task automatic poll(input logic [7:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0000_0000);
      n++;
    end while (q !== exp && n < 200);
    chk(q, exp);
  endtask : poll
  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (peer.got.size() < n && k < 400) begin
      @(posedge clk);
      k++;
    end
    chk(peer.got.size(), n);
  endtask : wait_got

  // reflected crc, one byte, least significant bit first
  function automatic logic [15:0] crc8(input logic [15:0] c,
                                       input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    return c;
  endfunction : crc8

  // ====================================================================
  // tests
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(A_COMMAND, 32'h0000_0000);
    rd(A_SERIAL_RATE, {24'h0, SERIAL_RATE_RST});
    wr(A_VERSION, 32'h0000_00FF);
    rd(A_VERSION, {24'h0, VERSION_ID});
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    $display("test map done");
    for (int p = 0; p < 4; p++) begin
      wr(A_MODE, p);
      wr(A_FIFO_DATA, 8'h10 + p);
      wr(A_FIFO_DATA, 32'h0000_00A5);
      wr(A_COMMAND, CMD_CRC);
      crc = crc8(crc8(pre[p], 8'h10 + p), 8'hA5);
      poll(A_CRC_RESULT, {16'h0, crc});
      wr(A_COMMAND, CMD_IDLE);
    end
    wr(A_COMMAND, CMD_CRC);
    poll(A_CRC_RESULT, {16'h0, CRC_PRE3});
    wr(A_FIFO_DATA, 32'h0000_003C);
    poll(A_CRC_RESULT, {16'h0, crc8(CRC_PRE3, 8'h3C)});
    rd(A_COMMAND, CMD_CRC);
    wr(A_COMMAND, 32'h0000_0027);
    rd(A_COMMAND, 32'h0000_0023);
    chk(power_down, 1'b1);
    wr(A_COMMAND, CMD_IDLE);
    $display("test crc done");
    peer.slow <= 1'b1;
    for (int i = 0; i < 3; i++) wr(A_FIFO_DATA, 8'hC1 + i);
    wr(A_COMMAND, CMD_TRANSMIT);
    poll(A_COMMAND, CMD_IDLE);
    chk(peer.got.size(), 3);
    foreach (peer.got[i]) chk(peer.got[i], 8'hC1 + i);
    peer.got.delete();
    base = irqs;
    wr(A_COMMAND, CMD_RECEIVE);
    @(posedge clk);
    chk(rx_en, 1'b1);
    peer.send('{8'h5E, 8'h6F});
    poll(A_COMMAND, CMD_IDLE);
    chk(rx_en, 1'b0);
    rd(A_FIFO_LEVEL, 32'h0000_0002);
    rd(A_FIFO_DATA, 32'h0000_005E);
    rd(A_FIFO_DATA, 32'h0000_006F);
    chk(irqs - base, 1);
    $display("test stream done");
    wr(A_FIFO_DATA, 32'h0000_0077);
    wr(A_COMMAND, CMD_TRANSCEIVE);
    repeat (20) @(posedge clk);
    chk(peer.got.size(), 0);
    wr(A_BIT_FRAMING, 32'h0000_0080);
    wait_got(1);
    peer.send('{8'h99});
    poll(A_FIFO_LEVEL, 32'h0000_0001);
    rd(A_FIFO_DATA, 32'h0000_0099);
    rd(A_COMMAND, CMD_TRANSCEIVE);
    wr(A_FIFO_DATA, 32'h0000_0078);
    wr(A_BIT_FRAMING, 32'h0000_0080);
    wait_got(2);
    chk(peer.got[1], 8'h78);
    $display("test transceive done");
    wr(A_CONTROL, 32'h0000_0000);
    wr(A_COMMAND, CMD_AUTO_ACT);
    base = irqs;
    peer.send('{8'h26});
    peer.set_field(1'b0);
    peer.set_field(1'b1);
    rd(A_COMMAND, CMD_AUTO_ACT);
    peer.pulse(MODE_P2P_106, 1'b0, 1'b0);
    chk({tx_crc, rx_crc}, 2'b11);
    peer.send('{8'hF0, 8'hD4, 8'h00, 8'hAA, 8'hBB});
    peer.pulse(MODE_P2P_106, 1'b1, 1'b0);
    poll(A_COMMAND, CMD_TRANSCEIVE);
    rd(A_STATUS2, 32'h0000_0001);
    chk({tx_crc, rx_crc}, 2'b00);
    chk(irqs - base, 1);
    rd(A_FIFO_LEVEL, 32'h0000_0005);
    rd(A_FIFO_DATA, 32'h0000_00F0);
    wr(A_COMMAND, CMD_AUTO_ACT);
    wr(A_COMMAND, CMD_AUTO_ACT);
    rd(A_COMMAND, CMD_AUTO_ACT);
    peer.pulse(MODE_CARD_A, 1'b0, 1'b1);
    rd(A_TX_MODE, 32'h0000_0020);
    peer.send('{8'h50, 8'h01, 8'hC2, 8'hD3});
    peer.pulse(MODE_CARD_A, 1'b1, 1'b1);
    poll(A_COMMAND, CMD_TRANSCEIVE);
    rd(A_FIFO_LEVEL, 32'h0000_0002);
    rd(A_FIFO_DATA, 32'h0000_0050);
    $display("test activation done");
    wr(A_SERIAL_RATE, 32'h0000_0055);
    rd(A_SERIAL_RATE, 32'h0000_0055);
    chk(serial_rate, 8'h55);
    wr(A_COMMAND, CMD_SOFT_RESET);
    poll(A_COMMAND, CMD_IDLE);
    rd(A_SERIAL_RATE, {24'h0, SERIAL_RATE_RST});
    rd(A_STATUS2, 32'h0000_0000);
    chk(serial_rate, SERIAL_RATE_RST);
    rd(A_FIFO_LEVEL, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      wr(A_TEST_SEL, sels[i]);
      repeat (2) @(posedge clk);
      chk(test_bus, buses[i]);
    end
    wr(A_COMMAND, CMD_SOFT_RESET);
    for (int i = 0; i < 25; i++) wr(A_FIFO_DATA, 32'h0000_0000);
    wr(A_COMMAND, CMD_CONFIG);
    wr(A_SELF_TEST, SELF_TEST_ON);
    wr(A_FIFO_DATA, 32'h0000_0000);
    wr(A_COMMAND, CMD_CRC);
    poll(A_FIFO_LEVEL, {25'h0, FIFO_FULL});
    $display("test reset and test bus done");
    wrap_up();
  end
endmodule : ctce_engine_bench
